// ### shared/ppm_pkg.sv
// Purpose: Constants and carriers for the port power management block
// Assumes: Core clock at 200 MHz; PHY and peer-port signals on that clock
// Notes:
// Notes on behaviour
// - Writing 11b to the power state field moves either D0 sub-state to D3hot.
// - In D3hot, writing zero to the power state field returns to D0 Uninitialized.
// - Only D0 and D3hot exist; D1 and D2 writes are ignored.
// - Any reset gives D0 Uninitialized; otherwise only software changes D-state.
// - In D0 Uninitialized, setting any of bus master, memory or I/O enable enters D0 Active.
// - In D3hot only Type 0 config and completions pass; memory, I/O and Type 1 config get UR.
// - Type 1 config toward a D3hot port ends as UR; Type 0 completes.
// - Upstream port entering D3hot starts the PCI-PM L1 entry sequence.
// - In D3hot a hot-plug or link state event raises a PME message.
// - Tx L0s floats Tx lanes; Rx L0s idles Rx; L1 idles Rx only, holds FC timers.
// - Receive lanes enter L0s regardless of transmitter L0s enable.
// - After FTS, receiver returns to L0 on lock, else goes to Recovery.
// - In L0s the link returns to L0 for FC updates within 30 us.
// - Upstream Tx L0s entry needs downstream receivers low, nothing sendable pending.
// - Tx L0s entry needs ASPM support field 01b or 11b.
// - Idle conditions must hold 1 us or 4 us, selected by one bit.
// - Downstream Tx L0s entry needs upstream receivers in L0s, nothing pending.
// - Upstream leaves L0s on pending traffic, peer exit, L1, D3hot or retrain.
// - A receiver leaving L0s or L1 sends a link state change message.
// - Downstream leaves L0s on pending traffic, peer exit, retrain/disable or L1 request.
// - On any Tx L0s exit the PHY sends FTS and then returns to L0.
// - With L0s enabled an idle transmit link is put into L0s.

package ppm_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int IDLE_SHORT_NS = 1000;
	localparam int IDLE_LONG_NS = 4000;
	localparam int FC_UPDATE_NS = 30000;
	localparam int IDLE_SHORT_CYC = (IDLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_LONG_CYC = (IDLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FC_UPDATE_CYC = FC_UPDATE_NS / CLK_PERIOD_NS;
	localparam int IDLE_CNT_W = 10;
	localparam int FC_CNT_W = 16;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_PMCSR = 12'h044;
	localparam logic [ADDR_W-1:0] ADDR_LCAP = 12'h074;
	localparam logic [ADDR_W-1:0] ADDR_LCTL = 12'h078;
	localparam logic [ADDR_W-1:0] ADDR_PMHP = 12'hf70;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 12'hf74;

	localparam int CMD_IO = 0;
	localparam int CMD_BM = 2;
	localparam int PS_LO = 0;
	localparam int PS_HI = 1;
	localparam int LCAP_ASPM_LO = 10;
	localparam int LCAP_ASPM_HI = 11;
	localparam int LCTL_ASPM_LO = 0;
	localparam int LCTL_ASPM_HI = 1;
	localparam int LCTL_DISABLE = 4;
	localparam int LCTL_RETRAIN = 5;
	localparam int PMHP_IDLE_SEL = 0;
	localparam int STAT_DST_LO = 0;
	localparam int STAT_TX_LO = 2;
	localparam int STAT_RX_LO = 4;

	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D3 = 2'h3;
	localparam logic [1:0] ASPM_L0S = 2'h1;
	localparam logic [1:0] ASPM_L0S_L1 = 2'h3;
	localparam logic [1:0] LCAP_RESET = 2'h3;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {D0_UNINIT, D0_ACTIVE, D3_HOT} ppm_dstate_type;
	typedef enum logic [1:0] {TX_L0, TX_L0S, TX_FTS} ppm_txst_type;
	typedef enum logic [1:0] {RX_L0, RX_L0S, RX_FTS, RX_RECOV} ppm_rxst_type;
	typedef enum logic [2:0] {REQ_MEM, REQ_IO, REQ_CFG0, REQ_CFG1, REQ_CPL} ppm_req_type;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic tlpPending;
		logic noCredits;
		logic dllpPending;
		logic peerRxLowPwr;
		logic peerRxExit;
		logic aspmL1Met;
		logic retrainReq;
		logic l1ReqBelow;
		logic hotPlugEvt;
		logic linkStateEvt;
		logic linkInL1;
	} ppm_cond_type;

	typedef struct packed {
		logic rxIdle;
		logic rxFtsDone;
		logic rxLock;
		logic rxL1Exit;
		logic txFtsDone;
	} ppm_phy_in_type;

	typedef struct packed {
		logic txEnterL0s;
		logic txSendFts;
		logic txHighZ;
		logic rxLowPower;
		logic fcTimerHold;
	} ppm_phy_out_type;

endpackage : ppm_pkg

// ### src/ppm_idle_timer.sv
// Purpose: Counts how long the L0s entry conditions have held
// Assumes: Reset is the synchronised copy from the port top
// Notes: Expired stays high while the conditions keep holding
`timescale 1ns/10ps

module ppm_idle_timer (
	input wire logic clk, // Core clock
	input wire logic rstn, // Synchronised reset, active low
	input wire logic condOk, // Entry conditions hold this cycle
	input wire logic longSel, // Select the long idle time
	output logic expired // Idle time elapsed
);

	typedef struct packed {
		logic [ppm_pkg::IDLE_CNT_W-1:0] cnt;
		logic done;
	} ppm_timer_state_type;

	localparam logic [ppm_pkg::IDLE_CNT_W-1:0] SHORT_LAST =
		ppm_pkg::IDLE_CNT_W'(ppm_pkg::IDLE_SHORT_CYC - 1);
	localparam logic [ppm_pkg::IDLE_CNT_W-1:0] LONG_LAST =
		ppm_pkg::IDLE_CNT_W'(ppm_pkg::IDLE_LONG_CYC - 1);

	ppm_timer_state_type s_q;
	ppm_timer_state_type s_d;
	logic [ppm_pkg::IDLE_CNT_W-1:0] last;

	always_comb begin
		s_d = s_q;
		last = longSel ? LONG_LAST : SHORT_LAST;
		if (!condOk) begin
			s_d.cnt = '0;
			s_d.done = 1'b0;
		end else if (s_q.cnt >= last) begin
			s_d.done = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expired = s_q.done;

endmodule : ppm_idle_timer

// ### src/ppm_port.sv
// Purpose: D-state control, request filtering and ASPM L0s control of one port
// Assumes: PHY status, peer-port status and traffic flags are on the core clock
// Notes: UPSTREAM selects upstream or downstream port behaviour
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps

module ppm_port #(
	parameter bit UPSTREAM = 1'b1,
	parameter int FC_UPDATE_CYCLES = ppm_pkg::FC_UPDATE_CYC
) (
	input wire logic clk, // Core clock, 200 MHz
	input wire logic rstn, // Fundamental reset, active low
	input wire logic hotReset, // Later reset, synchronous, active high
	input wire logic [ppm_pkg::ADDR_W-1:0] regAddr, // Register byte address
	input wire logic [ppm_pkg::DATA_W-1:0] regWdata, // Register write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [ppm_pkg::DATA_W-1:0] regRdata, // Read data, cycle after strobe
	input wire ppm_pkg::ppm_cond_type cond, // Traffic and peer-port status
	input wire ppm_pkg::ppm_phy_in_type phyIn, // PHY status
	input wire logic reqValid, // Incoming request valid
	input wire ppm_pkg::ppm_req_type reqKind, // Incoming request kind
	output ppm_pkg::ppm_phy_out_type phyOut, // PHY direction
	output logic reqAccept, // Request passes
	output logic reqUr, // Request ends as UR
	output logic lscMsg, // Link state change message
	output logic pmeMsg, // PME message
	output logic l1EntryReq, // Start PCI-PM L1 entry
	output ppm_pkg::ppm_dstate_type dState // Device power state
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [ppm_pkg::CMD_BM:ppm_pkg::CMD_IO] cmd;
		logic [1:0] ps;
		logic [1:0] aspmCap;
		logic [1:0] aspmCtl;
		logic retrain;
		logic linkOff;
		logic idleSel;
		ppm_pkg::ppm_dstate_type dst;
		ppm_pkg::ppm_txst_type tx;
		ppm_pkg::ppm_rxst_type rx;
		logic [ppm_pkg::FC_CNT_W-1:0] fcCnt;
		logic [ppm_pkg::DATA_W-1:0] rdata;
		ppm_pkg::ppm_phy_out_type phy;
		logic accept;
		logic ur;
		logic lsc;
		logic pme;
		logic l1Req;
	} ppm_port_state_type;

	localparam ppm_port_state_type RESET_STATE = '{
		cmd: '0,
		ps: ppm_pkg::PS_D0,
		aspmCap: ppm_pkg::LCAP_RESET,
		aspmCtl: '0,
		retrain: 1'b0,
		linkOff: 1'b0,
		idleSel: 1'b0,
		dst: ppm_pkg::D0_UNINIT,
		tx: ppm_pkg::TX_L0,
		rx: ppm_pkg::RX_L0,
		fcCnt: '0,
		rdata: '0,
		phy: '0,
		accept: 1'b0,
		ur: 1'b0,
		lsc: 1'b0,
		pme: 1'b0,
		l1Req: 1'b0
	};

	localparam logic [ppm_pkg::FC_CNT_W-1:0] FC_LAST =
		ppm_pkg::FC_CNT_W'(FC_UPDATE_CYCLES - 1);

	ppm_port_state_type s_q;
	ppm_port_state_type s_d;
	logic [1:0] rstSync_q;
	logic rstnInt;
	logic idleOk;
	logic idleExpired;
	logic l0sPermit;
	logic tlpSendable;
	logic peerIdle;
	logic exitCond;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic aspm_l0s_ok(input logic [1:0] field);
		aspm_l0s_ok = (field == ppm_pkg::ASPM_L0S) || (field == ppm_pkg::ASPM_L0S_L1);
	endfunction : aspm_l0s_ok

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end

	assign rstnInt = rstSync_q[1];

	// ----------------------------------------
	// L0s entry conditions
	// ----------------------------------------
	// A pending TLP without credits does not keep the link busy
	assign tlpSendable = cond.tlpPending && !cond.noCredits;
	assign peerIdle = cond.peerRxLowPwr;
	assign l0sPermit = aspm_l0s_ok(s_q.aspmCap)
		&& aspm_l0s_ok(s_q.aspmCtl)
		&& (s_q.dst != ppm_pkg::D3_HOT);
	assign idleOk = (s_q.tx == ppm_pkg::TX_L0) && l0sPermit && peerIdle
		&& !tlpSendable && !cond.dllpPending;

	ppm_idle_timer u_idle_timer (
		.clk(clk),
		.rstn(rstnInt),
		.condOk(idleOk),
		.longSel(s_q.idleSel),
		.expired(idleExpired)
	);

	// ----------------------------------------
	// L0s exit conditions
	// ----------------------------------------
	always_comb begin
		exitCond = tlpSendable || cond.dllpPending || cond.peerRxExit;
		if (UPSTREAM) begin
			exitCond = exitCond || cond.aspmL1Met
				|| (s_q.dst == ppm_pkg::D3_HOT) || cond.retrainReq;
		end else begin
			exitCond = exitCond || s_q.retrain
				|| s_q.linkOff || cond.l1ReqBelow;
		end
		if (s_q.fcCnt >= FC_LAST) begin
			exitCond = 1'b1;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rdata = '0;
		s_d.accept = 1'b0;
		s_d.ur = 1'b0;
		s_d.lsc = 1'b0;
		s_d.pme = 1'b0;
		s_d.l1Req = 1'b0;
		s_d.phy.txEnterL0s = 1'b0;

		// Register writes
		if (regWr) begin
			if (regAddr == ppm_pkg::ADDR_CMD) begin
				s_d.cmd = regWdata[ppm_pkg::CMD_BM:ppm_pkg::CMD_IO];
			end else if (regAddr == ppm_pkg::ADDR_PMCSR) begin
				// D1 and D2 codes leave the field unchanged
				if (regWdata[ppm_pkg::PS_HI:ppm_pkg::PS_LO] == ppm_pkg::PS_D0
					|| regWdata[ppm_pkg::PS_HI:ppm_pkg::PS_LO] == ppm_pkg::PS_D3) begin
					s_d.ps = regWdata[ppm_pkg::PS_HI:ppm_pkg::PS_LO];
				end
			end else if (regAddr == ppm_pkg::ADDR_LCAP) begin
				s_d.aspmCap = regWdata[ppm_pkg::LCAP_ASPM_HI:ppm_pkg::LCAP_ASPM_LO];
			end else if (regAddr == ppm_pkg::ADDR_LCTL) begin
				s_d.aspmCtl = regWdata[ppm_pkg::LCTL_ASPM_HI:ppm_pkg::LCTL_ASPM_LO];
				s_d.retrain = regWdata[ppm_pkg::LCTL_RETRAIN];
				s_d.linkOff = regWdata[ppm_pkg::LCTL_DISABLE];
			end else if (regAddr == ppm_pkg::ADDR_PMHP) begin
				s_d.idleSel = regWdata[ppm_pkg::PMHP_IDLE_SEL];
			end
		end

		// Register reads
		if (regRd) begin
			if (regAddr == ppm_pkg::ADDR_CMD) begin
				s_d.rdata[ppm_pkg::CMD_BM:ppm_pkg::CMD_IO] = s_q.cmd;
			end else if (regAddr == ppm_pkg::ADDR_PMCSR) begin
				s_d.rdata[ppm_pkg::PS_HI:ppm_pkg::PS_LO] = s_q.ps;
			end else if (regAddr == ppm_pkg::ADDR_LCAP) begin
				s_d.rdata[ppm_pkg::LCAP_ASPM_HI:ppm_pkg::LCAP_ASPM_LO] = s_q.aspmCap;
			end else if (regAddr == ppm_pkg::ADDR_LCTL) begin
				s_d.rdata[ppm_pkg::LCTL_ASPM_HI:ppm_pkg::LCTL_ASPM_LO] = s_q.aspmCtl;
				s_d.rdata[ppm_pkg::LCTL_RETRAIN] = s_q.retrain;
				s_d.rdata[ppm_pkg::LCTL_DISABLE] = s_q.linkOff;
			end else if (regAddr == ppm_pkg::ADDR_PMHP) begin
				s_d.rdata[ppm_pkg::PMHP_IDLE_SEL] = s_q.idleSel;
			end else if (regAddr == ppm_pkg::ADDR_STAT) begin
				s_d.rdata[ppm_pkg::STAT_DST_LO +: 2] = s_q.dst;
				s_d.rdata[ppm_pkg::STAT_TX_LO +: 2] = s_q.tx;
				s_d.rdata[ppm_pkg::STAT_RX_LO +: 2] = s_q.rx;
			end
		end

		// Device power state, follows the written field values
		case (s_q.dst)
			ppm_pkg::D0_UNINIT: begin
				if (s_d.ps == ppm_pkg::PS_D3) begin
					s_d.dst = ppm_pkg::D3_HOT;
				end else if (regWr && regAddr == ppm_pkg::ADDR_CMD && |s_d.cmd) begin
					// Stale enables left from before D3hot must not wake the port
					s_d.dst = ppm_pkg::D0_ACTIVE;
				end
			end
			ppm_pkg::D0_ACTIVE: begin
				if (s_d.ps == ppm_pkg::PS_D3) begin
					s_d.dst = ppm_pkg::D3_HOT;
				end
			end
			ppm_pkg::D3_HOT: begin
				if (s_d.ps == ppm_pkg::PS_D0) begin
					s_d.dst = ppm_pkg::D0_UNINIT;
				end
			end
			default: begin
				s_d.dst = ppm_pkg::D0_UNINIT;
			end
		endcase

		// PCI-PM L1 request on D3hot entry
		if (UPSTREAM && s_q.dst != ppm_pkg::D3_HOT && s_d.dst == ppm_pkg::D3_HOT) begin
			s_d.l1Req = 1'b1;
		end

		// Wake events while in D3hot
		if (s_q.dst == ppm_pkg::D3_HOT && (cond.hotPlugEvt || cond.linkStateEvt)) begin
			s_d.pme = 1'b1;
		end

		// Request filtering
		if (reqValid) begin
			if (s_q.dst == ppm_pkg::D3_HOT) begin
				if (reqKind == ppm_pkg::REQ_CFG0 || reqKind == ppm_pkg::REQ_CPL) begin
					s_d.accept = 1'b1;
				end else begin
					s_d.ur = 1'b1;
				end
			end else begin
				s_d.accept = 1'b1;
			end
		end

		// Transmit link state
		case (s_q.tx)
			ppm_pkg::TX_L0: begin
				s_d.fcCnt = '0;
				if (idleExpired) begin
					s_d.tx = ppm_pkg::TX_L0S;
					s_d.phy.txEnterL0s = 1'b1;
				end
			end
			ppm_pkg::TX_L0S: begin
				s_d.fcCnt = s_q.fcCnt + 1'b1;
				if (exitCond) begin
					s_d.tx = ppm_pkg::TX_FTS;
					s_d.fcCnt = '0;
				end
			end
			ppm_pkg::TX_FTS: begin
				if (phyIn.txFtsDone) begin
					s_d.tx = ppm_pkg::TX_L0;
				end
			end
			default: begin
				s_d.tx = ppm_pkg::TX_L0;
			end
		endcase

		// Receive link state, independent of transmit enable
		case (s_q.rx)
			ppm_pkg::RX_L0: begin
				if (phyIn.rxIdle) begin
					s_d.rx = ppm_pkg::RX_L0S;
				end
			end
			ppm_pkg::RX_L0S: begin
				if (!phyIn.rxIdle) begin
					s_d.rx = ppm_pkg::RX_FTS;
					s_d.lsc = 1'b1;
				end
			end
			ppm_pkg::RX_FTS: begin
				if (phyIn.rxFtsDone) begin
					s_d.rx = phyIn.rxLock ? ppm_pkg::RX_L0 : ppm_pkg::RX_RECOV;
				end
			end
			ppm_pkg::RX_RECOV: begin
				if (phyIn.rxLock) begin
					s_d.rx = ppm_pkg::RX_L0;
				end
			end
			default: begin
				s_d.rx = ppm_pkg::RX_L0;
			end
		endcase

		if (phyIn.rxL1Exit) begin
			s_d.lsc = 1'b1;
		end

		// PHY lane direction
		s_d.phy.txSendFts = (s_d.tx == ppm_pkg::TX_FTS);
		s_d.phy.txHighZ = (s_d.tx == ppm_pkg::TX_L0S);
		s_d.phy.rxLowPower = (s_d.rx == ppm_pkg::RX_L0S) || cond.linkInL1;
		s_d.phy.fcTimerHold = cond.linkInL1;

		// Later reset returns everything to D0 Uninitialized
		if (hotReset) begin
			s_d = RESET_STATE;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign regRdata = s_q.rdata;
	assign phyOut = s_q.phy;
	assign reqAccept = s_q.accept;
	assign reqUr = s_q.ur;
	assign lscMsg = s_q.lsc;
	assign pmeMsg = s_q.pme;
	assign l1EntryReq = s_q.l1Req;
	assign dState = s_q.dst;

endmodule : ppm_port

// ### tb/ppm_phy_model.sv
// Purpose: Behavioural PHY and link partner for ppm_port
// Assumes: Bench commands receiver idle and lock outcome
// Notes: FTS bursts are shortened to a few cycles
`timescale 1ns/10ps

module ppm_phy_model #(
	parameter int FTS_CYC = 4
) (
	input wire logic clk, // Core clock
	input wire logic rstn, // Reset, active low
	input wire ppm_pkg::ppm_phy_out_type phyOut, // PHY direction
	input wire logic rxIdleCmd, // Partner sends idle
	input wire logic lockOk, // Lock after FTS
	output ppm_pkg::ppm_phy_in_type phyIn // PHY status
);
	int txCnt;
	int rxCnt;
	logic idleQ;
	logic ftsQ;
	logic txDoneQ;
	// No lock while the far end is idle
	assign phyIn = '{rxIdle: rxIdleCmd, rxFtsDone: ftsQ, rxLock: lockOk && !rxIdleCmd,
		rxL1Exit: 1'b0, txFtsDone: txDoneQ};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txCnt <= 0;
			rxCnt <= 0;
			idleQ <= 1'b0;
			ftsQ <= 1'b0;
			txDoneQ <= 1'b0;
		end else begin
			idleQ <= rxIdleCmd;
			txCnt <= phyOut.txSendFts ? txCnt + 1 : 0;
			txDoneQ <= phyOut.txSendFts && txCnt == FTS_CYC - 1;
			rxCnt <= (idleQ && !rxIdleCmd) ? 3 : (rxCnt > 0 ? rxCnt - 1 : 0);
			ftsQ <= rxCnt == 1;
		end
	end
endmodule : ppm_phy_model

// ### tb/ppm_port_props.sv
// Purpose: Port-level properties of ppm_port
// Assumes: Upstream role; rstn low disables all checks
// Notes: Idle time is judged from traffic inputs and the D3hot state only
`timescale 1ns/10ps

module ppm_port_props #(
	parameter int FC_UPDATE_CYCLES = ppm_pkg::FC_UPDATE_CYC
) (
	input wire logic clk, // Core clock
	input wire logic rstn, // Reset, active low
	input wire logic hotReset, // Later reset
	input wire logic [11:0] regAddr, // Address
	input wire logic [31:0] regWdata, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	input wire logic [31:0] regRdata, // Read data
	input wire ppm_pkg::ppm_cond_type cond, // Traffic status
	input wire ppm_pkg::ppm_phy_in_type phyIn, // PHY status
	input wire logic reqValid, // Request valid
	input wire ppm_pkg::ppm_req_type reqKind, // Request kind
	input wire ppm_pkg::ppm_phy_out_type phyOut, // PHY direction
	input wire logic reqAccept, // Request passes
	input wire logic reqUr, // Request ends as UR
	input wire logic lscMsg, // Link state message
	input wire logic pmeMsg, // PME message
	input wire logic l1EntryReq, // L1 entry start
	input wire ppm_pkg::ppm_dstate_type dState // Device state
);
	// ----
	// Helpers
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic condOk;
	logic pmWr;
	logic d3;
	logic [7:0] heldQ;
	int hzQ;
	assign d3 = dState == ppm_pkg::D3_HOT;
	assign pmWr = regWr && regAddr == ppm_pkg::ADDR_PMCSR && !hotReset;
	assign condOk = cond.peerRxLowPwr && !cond.dllpPending && !d3
		&& !(cond.tlpPending && !cond.noCredits);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			heldQ <= 8'h0;
			hzQ <= 0;
		end else begin
			heldQ <= !condOk ? 8'h0 : (heldQ == 8'hff ? heldQ : heldQ + 8'h1);
			hzQ <= phyOut.txHighZ ? hzQ + 1 : 0;
		end
	end
	// ----
	// Properties
	// ----
	a_idle_time: assert property (phyOut.txEnterL0s |-> heldQ >= 8'hc3)
		else $error("L0s entered before idle time");
	a_fc_return: assert property (hzQ <= FC_UPDATE_CYCLES + 2)
		else $error("L0s held past update interval");
	a_ur_block: assert property (reqValid && d3 && (reqKind == ppm_pkg::REQ_MEM
		|| reqKind == ppm_pkg::REQ_IO || reqKind == ppm_pkg::REQ_CFG1) |=> reqUr && !reqAccept)
		else $error("blocked request not refused");
	a_req_pass: assert property (reqValid && (!d3 || reqKind == ppm_pkg::REQ_CFG0
		|| reqKind == ppm_pkg::REQ_CPL) |=> reqAccept && !reqUr)
		else $error("request not accepted");
	a_d3_entry: assert property (pmWr && regWdata[1:0] == 2'h3 |=> d3)
		else $error("no D3hot after write");
	a_d3_exit: assert property (pmWr && regWdata[1:0] == 2'h0 && d3
		|=> dState == ppm_pkg::D0_UNINIT)
		else $error("no D0 uninitialized after clear");
	a_d12_ignored: assert property (pmWr && regWdata[1] != regWdata[0] |=> $stable(dState))
		else $error("intermediate state accepted");
	a_sw_only: assert property (!regWr && !hotReset |=> $stable(dState))
		else $error("state changed without software");
	a_hot_reset: assert property (hotReset |=> dState == ppm_pkg::D0_UNINIT)
		else $error("reset did not give D0 uninitialized");
	a_cmd_active: assert property (regWr && regAddr == ppm_pkg::ADDR_CMD && !hotReset
		&& regWdata[2:0] != 3'h0 && dState == ppm_pkg::D0_UNINIT |=> dState == ppm_pkg::D0_ACTIVE)
		else $error("no D0 active after enable");
	a_pme_d3: assert property ((cond.hotPlugEvt || cond.linkStateEvt) && d3 |=> pmeMsg)
		else $error("no PME message");
	a_l1_start: assert property (pmWr && regWdata[1:0] == 2'h3 && !d3 |-> ##[1:2] l1EntryReq)
		else $error("no L1 entry start");
	a_fts_exit: assert property (phyOut.txHighZ && cond.dllpPending
		|=> phyOut.txSendFts && !phyOut.txHighZ)
		else $error("no FTS on exit");
	a_rx_lowpwr: assert property ($rose(phyIn.rxIdle) |=> phyOut.rxLowPower)
		else $error("receiver not in low power");
	a_lsc_rx: assert property ($fell(phyIn.rxIdle) |=> lscMsg)
		else $error("no link state message");
endmodule : ppm_port_props

bind ppm_port ppm_port_props #(.FC_UPDATE_CYCLES(FC_UPDATE_CYCLES)) propsU (.*);

// ### tb/ppm_port_test.sv
// Purpose: Self-checking bench for ppm_port
// Assumes: Upstream role, short update count
// Notes: PHY model answers FTS bursts
`timescale 1ns/10ps

module ppm_port_test;
	// ----
	// Signals
	// ----
	localparam int FC = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hotReset = 1'b0;
	logic [11:0] regAddr = 12'h0;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	ppm_pkg::ppm_cond_type cond = '0;
	ppm_pkg::ppm_phy_in_type phyIn;
	ppm_pkg::ppm_phy_out_type phyOut;
	logic reqValid = 1'b0;
	ppm_pkg::ppm_req_type reqKind = ppm_pkg::REQ_MEM;
	logic reqAccept, reqUr, lscMsg, pmeMsg, l1EntryReq;
	ppm_pkg::ppm_dstate_type dState;
	logic rxIdleCmd = 1'b0;
	logic lockOk = 1'b1;
	logic [31:0] rdv;
	int errCount = 0;
	int comparisons = 0;
	always #2.5 clk = ~clk;
	ppm_port #(.UPSTREAM(1'b1), .FC_UPDATE_CYCLES(FC)) dut_u (.*);
	ppm_phy_model phy_u (.*);
	// ----
	// Tasks
	// ----
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errCount++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic giveVerdict();
		$display("comparisons %0d mismatches %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : giveVerdict
	task automatic wr(logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(logic [11:0] a);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rdv = regRdata;
	endtask : rd
	function automatic logic hit(int s);
		case (s)
			0: return phyOut.txEnterL0s === 1'b1;
			1: return phyOut.txSendFts === 1'b0;
			2: return l1EntryReq === 1'b1;
			default: return phyOut.txSendFts === 1'b1;
		endcase
	endfunction : hit
	task automatic waitHit(int s, int lim, output int n);
		n = 0;
		#1;
		while (!hit(s)) begin
			@(posedge clk);
			#1 n++;
			if (n > lim) begin
				errCount++;
				giveVerdict();
			end
		end
	endtask : waitHit
	task automatic pulse(logic [10:0] m);
		@(posedge clk);
		cond <= ppm_pkg::ppm_cond_type'(cond | m);
		@(posedge clk);
		cond <= ppm_pkg::ppm_cond_type'(cond & ~m);
	endtask : pulse
	task automatic req(int k, logic ur);
		@(posedge clk);
		reqValid <= 1'b1;
		reqKind <= ppm_pkg::ppm_req_type'(k);
		@(posedge clk);
		reqValid <= 1'b0;
		#1 chk("reqUr", reqUr, ur);
		chk("reqAccept", reqAccept, !ur);
	endtask : req
	// ----
	// Scenarios
	// ----
	task automatic sReset();
		rd(12'hf74);
		chk("status", rdv, 32'h0);
		rd(12'h074);
		chk("aspmCap", rdv, 32'h00000c00);
		rd(12'h100);
		chk("unmapped", rdv, 32'h0);
	endtask : sReset
	task automatic sDstate();
		int n;
		int i;
		wr(12'h044, 32'h1);
		wr(12'h044, 32'h2);
		#1 chk("dNoD12", dState, ppm_pkg::D0_UNINIT);
		req(0, 1'b0);
		wr(12'h004, 32'h2);
		#1 chk("dActive", dState, ppm_pkg::D0_ACTIVE);
		wr(12'h044, 32'h3);
		waitHit(2, 3, n);
		chk("dHot", dState, ppm_pkg::D3_HOT);
		for (i = 0; i < 5; i++) begin
			req(i, i < 2 || i == 3);
		end
		for (i = 0; i < 2; i++) begin
			pulse(i == 0 ? 11'h004 : 11'h002);
			#1 chk("pme", pmeMsg, 1'b1);
		end
		wr(12'h044, 32'h0);
		#1 chk("dClear", dState, ppm_pkg::D0_UNINIT);
		wr(12'h044, 32'h3);
		@(posedge clk);
		hotReset <= 1'b1;
		@(posedge clk);
		hotReset <= 1'b0;
		#1 chk("dReset", dState, ppm_pkg::D0_UNINIT);
	endtask : sDstate
	task automatic sL0s();
		int n;
		int i;
		logic [10:0] ex [5];
		ex = '{11'h400, 11'h100, 11'h040, 11'h020, 11'h010};
		wr(12'h078, 32'h1);
		cond.peerRxLowPwr <= 1'b1;
		repeat (150) @(posedge clk);
		pulse(11'h100);
		waitHit(0, 260, n);
		chk("idleShort", n >= 195 && n <= 210, 1'b1);
		chk("txHighZ", phyOut.txHighZ, 1'b1);
		@(posedge clk);
		cond.tlpPending <= 1'b1;
		cond.noCredits <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("noCredit", phyOut.txHighZ, 1'b1);
		@(posedge clk);
		cond.tlpPending <= 1'b0;
		cond.noCredits <= 1'b0;
		waitHit(3, FC + 5, n);
		waitHit(1, 30, n);
		for (i = 0; i < 5; i++) begin
			waitHit(0, 260, n);
			pulse(ex[i]);
			#1 chk("exitFts", phyOut.txSendFts, 1'b1);
			waitHit(1, 30, n);
		end
		wr(12'h074, 32'h00000800);
		n = 0;
		for (i = 0; i < 250; i++) begin
			@(posedge clk);
			#1 n += (phyOut.txEnterL0s === 1'b1);
		end
		chk("capDenied", n, 32'h0);
		wr(12'h074, 32'h00000400);
		wr(12'hf70, 32'h1);
		waitHit(0, 900, n);
		chk("idleLong", n >= 790 && n <= 810, 1'b1);
		wr(12'h078, 32'h0);
	endtask : sL0s
	task automatic sRx();
		@(posedge clk);
		rxIdleCmd <= 1'b1;
		@(posedge clk);
		#1 chk("rxLow", phyOut.rxLowPower, 1'b1);
		@(posedge clk);
		rxIdleCmd <= 1'b0;
		lockOk <= 1'b0;
		@(posedge clk);
		#1 chk("lsc", lscMsg, 1'b1);
		repeat (6) @(posedge clk);
		rd(12'hf74);
		chk("rxRecov", rdv[5:4], 2'h3);
		lockOk <= 1'b1;
		repeat (3) @(posedge clk);
		rd(12'hf74);
		chk("rxL0", rdv[5:4], 2'h0);
		pulse(11'h001);
		#1 chk("fcHold", phyOut.fcTimerHold, 1'b1);
	endtask : sRx
	// ----
	// Sequence
	// ----
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		sReset();
		sDstate();
		sL0s();
		sRx();
		giveVerdict();
	end
	initial begin
		#100000;
		errCount++;
		giveVerdict();
	end
endmodule : ppm_port_test
